// *** rtl/cfm_defs.svh ***
// constants for the front-panel setup menu: positions, limits, timing
`ifndef CFM_DEFS_SVH
`define CFM_DEFS_SVH

`define CFM_CLK_KHZ 50000
`define CFM_HOLD_MS 5000
`define CFM_ALT_MS 400
`define CFM_MSG_MS 1000
`define CFM_HOLD_CYC (`CFM_HOLD_MS * `CFM_CLK_KHZ)
`define CFM_ALT_CYC (`CFM_ALT_MS * `CFM_CLK_KHZ)
`define CFM_MSG_CYC (`CFM_MSG_MS * `CFM_CLK_KHZ)

`define CFM_POS_BANNER 5'h00
`define CFM_POS_ADDR 5'h01
`define CFM_POS_BAUD 5'h02
`define CFM_POS_TRIM_G 5'h06
`define CFM_POS_INST_G2 5'h0A
`define CFM_POS_CURVE_G 5'h0C
`define CFM_POS_CTPRI_P 5'h0D
`define CFM_POS_CTSEC_P 5'h0E
`define CFM_POS_CTPRI_G 5'h0F
`define CFM_POS_CTSEC_G 5'h10
`define CFM_POS_SPAN_P 5'h11
`define CFM_POS_SPAN_G 5'h12
`define CFM_POS_DEMAND 5'h13
`define CFM_POS_GND_EN 5'h14
`define CFM_POS_GND_INST 5'h15
`define CFM_POS_AUX_OUT 5'h17
`define CFM_POS_LAST 5'h18

`define CFM_ADDR_MIN 16'h0001
`define CFM_ADDR_MAX 16'h00FE
`define CFM_ADDR_DEF 16'h00DE
`define CFM_BAUD_MAX 16'h0006
`define CFM_BAUD_DEF 16'h0002
`define CFM_DIAL_MAX 16'h0063
`define CFM_INST_MIN 16'h004B
`define CFM_INST_MAX 16'h07D0
`define CFM_INST_DEF 16'h0064
`define CFM_CURVE_MAX 16'h000F
`define CFM_CT_MIN 16'h0005
`define CFM_CT_MAX 16'h1388
`define CFM_CT_STEP 16'h0005
`define CFM_CTSEC 16'h0005
`define CFM_DEMAND_MIN 16'h0001
`define CFM_DEMAND_MAX 16'h001E
`define CFM_DEMAND_DEF 16'h000F
`define CFM_FLAG_MAX 16'h0001

`define CFM_REG_STATUS 8'h00
`define CFM_REG_CTRL 8'h01
`define CFM_REG_VAL_BASE 3'h1
`define CFM_CTRL_LOCK_BIT 0

`endif

// *** rtl/cfm_pkg.sv ***
// types for the front-panel setup menu
package cfm_pkg;

    typedef enum logic [6:0] {
        CFM_NORMAL = 7'h01,
        CFM_ENTER_HOLD = 7'h02,
        CFM_ENTER_WAIT = 7'h04,
        CFM_SETUP = 7'h08,
        CFM_EXIT_HOLD = 7'h10,
        CFM_STORE = 7'h20,
        CFM_STORE_MSG = 7'h40
    } cfm_state_t;

    typedef enum logic [2:0] {
        CFM_SHOW_BLANK = 3'h0,
        CFM_SHOW_NORMAL = 3'h1,
        CFM_SHOW_BANNER = 3'h2,
        CFM_SHOW_NAME = 3'h3,
        CFM_SHOW_VALUE = 3'h4,
        CFM_SHOW_STORED = 3'h5
    } cfm_show_t;

endpackage : cfm_pkg

// *** rtl/cfm_timer.sv ***
// elapsed-time counter with run, clear and a run-time limit
module cfm_timer (
    input wire logic sys_clk, // system clock
    input wire logic rst_n, // sync reset, active low
    input wire logic run, // count while high, restart when low
    input wire logic clear, // restart from zero
    input wire logic [27:0] limit, // cycles until done
    output logic done // high once limit cycles have run
);

    logic [27:0] count;

    always_ff @(posedge sys_clk) begin
        if (!rst_n || !run || clear) begin
            count <= 28'h0000000;
            done <= 1'b0;
        end else if (!done) begin
            if (count == limit - 28'h0000001) begin
                done <= 1'b1;
            end else begin
                count <= count + 28'h0000001;
            end
        end
    end

endmodule : cfm_timer

// *** rtl/cfm_menu.sv ***
// front-panel setup menu sequencer with working copy and store
`include "cfm_defs.svh"

module cfm_menu #(
    parameter logic [27:0] HOLD_CYCLES = 28'(`CFM_HOLD_CYC),
    parameter logic [27:0] ALT_CYCLES = 28'(`CFM_ALT_CYC),
    parameter logic [27:0] MSG_CYCLES = 28'(`CFM_MSG_CYC)
) (
    input wire logic sys_clk, // system clock, 50 MHz
    input wire logic rst_n, // sync reset, active low
    input wire logic step_up, // step switch raised (level)
    input wire logic step_down, // step switch depressed (level)
    input wire logic adj_up, // adjust switch raised (level)
    input wire logic adj_down, // adjust switch depressed (level)
    input wire logic aux_fitted, // auxiliary output contact present
    input wire logic span_phase_hi, // factory strap, phase span high
    input wire logic span_ground_hi, // factory strap, ground span high
    input wire logic [7:0] reg_addr, // register address
    input wire logic [15:0] reg_wdata, // register write data
    input wire logic reg_wr, // register write strobe
    input wire logic reg_rd, // register read strobe
    output logic [15:0] reg_rdata, // read data, cycle after strobe
    output logic setup_indicator, // setup mode lamp
    output logic protect_enable, // protection functions allowed
    output cfm_pkg::cfm_show_t disp_kind, // what the display shows
    output logic [4:0] disp_item, // item position shown
    output logic [15:0] disp_value, // item value shown
    output logic nv_wr, // nonvolatile write pulse
    output logic [4:0] nv_addr, // nonvolatile item index
    output logic [15:0] nv_data // nonvolatile item value
);

    cfm_pkg::cfm_state_t state;
    logic [4:0] pos;
    logic [4:0] store_idx;
    logic show_name;
    logic step_down_q, step_up_q, adj_up_q, adj_down_q;
    logic press, up_rise, adj_evt;
    logic adj_lock;
    logic hold_run, hold_done, alt_run, alt_done;
    logic [27:0] hold_limit;
    logic [15:0] work [0:24];
    logic [15:0] saved [0:24];

    // ------------------------------------------------------------
    // item range decoding
    // ------------------------------------------------------------
    function automatic logic [15:0] item_min(input logic [4:0] p);
        if (p == `CFM_POS_ADDR) item_min = `CFM_ADDR_MIN;
        else if (p > `CFM_POS_TRIM_G && p <= `CFM_POS_INST_G2)
            item_min = `CFM_INST_MIN;
        else if (p == `CFM_POS_CTPRI_P || p == `CFM_POS_CTPRI_G)
            item_min = `CFM_CT_MIN;
        else if (p == `CFM_POS_CTSEC_P || p == `CFM_POS_CTSEC_G)
            item_min = `CFM_CTSEC;
        else if (p == `CFM_POS_DEMAND) item_min = `CFM_DEMAND_MIN;
        else item_min = 16'h0000;
    endfunction : item_min

    function automatic logic [15:0] item_max(input logic [4:0] p);
        if (p == `CFM_POS_ADDR) item_max = `CFM_ADDR_MAX;
        else if (p == `CFM_POS_BAUD) item_max = `CFM_BAUD_MAX;
        else if (p <= `CFM_POS_TRIM_G) item_max = `CFM_DIAL_MAX;
        else if (p <= `CFM_POS_INST_G2) item_max = `CFM_INST_MAX;
        else if (p <= `CFM_POS_CURVE_G) item_max = `CFM_CURVE_MAX;
        else if (p == `CFM_POS_CTPRI_P || p == `CFM_POS_CTPRI_G)
            item_max = `CFM_CT_MAX;
        else if (p == `CFM_POS_CTSEC_P || p == `CFM_POS_CTSEC_G)
            item_max = `CFM_CTSEC;
        else if (p == `CFM_POS_DEMAND) item_max = `CFM_DEMAND_MAX;
        else item_max = `CFM_FLAG_MAX;
    endfunction : item_max

    function automatic logic [15:0] item_default(input logic [4:0] p);
        if (p == `CFM_POS_ADDR) item_default = `CFM_ADDR_DEF;
        else if (p == `CFM_POS_BAUD) item_default = `CFM_BAUD_DEF;
        else if (p > `CFM_POS_TRIM_G && p <= `CFM_POS_INST_G2)
            item_default = `CFM_INST_DEF;
        else if (p == `CFM_POS_DEMAND) item_default = `CFM_DEMAND_DEF;
        else item_default = item_min(p);
    endfunction : item_default

    function automatic logic item_fixed(input logic [4:0] p);
        item_fixed = p == `CFM_POS_CTSEC_P || p == `CFM_POS_CTSEC_G ||
                     p == `CFM_POS_SPAN_P || p == `CFM_POS_SPAN_G;
    endfunction : item_fixed

    // clamps at the limits; the line speed code alone wraps around
    function automatic logic [15:0] adj_val(input logic [4:0] p,
                                            input logic [15:0] v,
                                            input logic up);
        logic [15:0] st, lo, hi;
        logic [16:0] sum;
        st = (p == `CFM_POS_CTPRI_P || p == `CFM_POS_CTPRI_G) ?
             `CFM_CT_STEP : 16'h0001;
        lo = item_min(p);
        hi = item_max(p);
        sum = {1'b0, v} + {1'b0, st};
        if (item_fixed(p)) adj_val = v;
        else if (p == `CFM_POS_BAUD && up)
            adj_val = (v >= hi) ? lo : v + 16'h0001;
        else if (p == `CFM_POS_BAUD)
            adj_val = (v <= lo) ? hi : v - 16'h0001;
        else if (up) adj_val = (sum > {1'b0, hi}) ? hi : sum[15:0];
        else adj_val = (v < lo + st) ? lo : v - st;
    endfunction : adj_val

    // sub-items are skipped unless their condition holds
    function automatic logic [4:0] next_pos(input logic [4:0] p,
                                            input logic gnd,
                                            input logic aux);
        logic [4:0] n;
        n = p + 5'h01;
        if (n == `CFM_POS_GND_INST && !gnd) n = `CFM_POS_AUX_OUT;
        if (n == `CFM_POS_AUX_OUT && !aux) n = `CFM_POS_LAST;
        if (p == `CFM_POS_LAST) n = `CFM_POS_BANNER;
        next_pos = n;
    endfunction : next_pos

    // ------------------------------------------------------------
    // switch edges and timers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            step_down_q <= 1'b0;
            step_up_q <= 1'b0;
            adj_up_q <= 1'b0;
            adj_down_q <= 1'b0;
        end else begin
            step_down_q <= step_down;
            step_up_q <= step_up;
            adj_up_q <= adj_up;
            adj_down_q <= adj_down;
        end
    end

    // a step counts on release, so holding down never repeats
    assign press = step_down_q && !step_down;
    assign up_rise = step_up && !step_up_q;
    assign adj_evt = (adj_up && !adj_up_q) || (adj_down && !adj_down_q);

    assign hold_run = state == cfm_pkg::CFM_ENTER_HOLD ||
                      state == cfm_pkg::CFM_EXIT_HOLD ||
                      state == cfm_pkg::CFM_STORE_MSG;
    assign hold_limit = (state == cfm_pkg::CFM_STORE_MSG) ?
                        MSG_CYCLES : HOLD_CYCLES;
    assign alt_run = state == cfm_pkg::CFM_SETUP &&
                     pos != `CFM_POS_BANNER && show_name;

    cfm_timer u_hold (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(hold_run),
        .clear(1'b0),
        .limit(hold_limit),
        .done(hold_done)
    );

    cfm_timer u_alt (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(alt_run),
        .clear(press || up_rise),
        .limit(ALT_CYCLES),
        .done(alt_done)
    );

    // ------------------------------------------------------------
    // mode sequence
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= cfm_pkg::CFM_NORMAL;
        end else begin
            case (state)
                cfm_pkg::CFM_NORMAL: begin
                    // edge, not level: a hold left over from exit is ignored
                    if (up_rise) state <= cfm_pkg::CFM_ENTER_HOLD;
                end
                cfm_pkg::CFM_ENTER_HOLD: begin
                    if (!step_up) state <= cfm_pkg::CFM_NORMAL;
                    else if (hold_done)
                        state <= cfm_pkg::CFM_ENTER_WAIT;
                end
                cfm_pkg::CFM_ENTER_WAIT: begin
                    if (!step_up) state <= cfm_pkg::CFM_SETUP;
                end
                cfm_pkg::CFM_SETUP: begin
                    if (pos == `CFM_POS_BANNER && up_rise)
                        state <= cfm_pkg::CFM_EXIT_HOLD;
                end
                cfm_pkg::CFM_EXIT_HOLD: begin
                    if (!step_up) state <= cfm_pkg::CFM_SETUP;
                    else if (hold_done) state <= cfm_pkg::CFM_STORE;
                end
                cfm_pkg::CFM_STORE: begin
                    if (store_idx == `CFM_POS_LAST)
                        state <= cfm_pkg::CFM_STORE_MSG;
                end
                cfm_pkg::CFM_STORE_MSG: begin
                    if (hold_done) state <= cfm_pkg::CFM_NORMAL;
                end
                default: state <= cfm_pkg::CFM_NORMAL;
            endcase
        end
    end

    // ------------------------------------------------------------
    // item position and name/value alternation
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n || state != cfm_pkg::CFM_SETUP) begin
            pos <= `CFM_POS_BANNER;
            show_name <= 1'b0;
        end else if (press) begin
            pos <= next_pos(pos, work[`CFM_POS_GND_EN][0],
                            aux_fitted);
            show_name <= 1'b1;
        end else if (up_rise && pos != `CFM_POS_BANNER) begin
            show_name <= 1'b1;
        end else if (alt_done || adj_evt) begin
            show_name <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // working copy and store to nonvolatile memory
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 25; i++) begin
                work[i] <= item_default(5'(i));
            end
        end else begin
            if (state == cfm_pkg::CFM_SETUP && pos != `CFM_POS_BANNER &&
                adj_evt && !adj_lock) begin
                work[pos] <= adj_val(pos, work[pos],
                                     adj_up && !adj_up_q);
            end
            work[`CFM_POS_SPAN_P] <= {15'h0000, span_phase_hi};
            work[`CFM_POS_SPAN_G] <= {15'h0000, span_ground_hi};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 25; i++) begin
                saved[i] <= item_default(5'(i));
            end
            store_idx <= `CFM_POS_ADDR;
            nv_wr <= 1'b0;
            nv_addr <= 5'h00;
            nv_data <= 16'h0000;
        end else if (state == cfm_pkg::CFM_STORE) begin
            // only changed items cost a write cycle in storage
            nv_wr <= work[store_idx] != saved[store_idx];
            nv_addr <= store_idx;
            nv_data <= work[store_idx];
            saved[store_idx] <= work[store_idx];
            store_idx <= store_idx + 5'h01;
        end else begin
            nv_wr <= 1'b0;
            store_idx <= `CFM_POS_ADDR;
        end
    end

    // ------------------------------------------------------------
    // display and mode outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            setup_indicator <= 1'b0;
            protect_enable <= 1'b1;
            disp_kind <= cfm_pkg::CFM_SHOW_NORMAL;
            disp_item <= 5'h00;
            disp_value <= 16'h0000;
        end else begin
            setup_indicator <= !(state == cfm_pkg::CFM_NORMAL ||
                                 state == cfm_pkg::CFM_ENTER_HOLD ||
                                 state == cfm_pkg::CFM_ENTER_WAIT);
            protect_enable <= state == cfm_pkg::CFM_NORMAL ||
                              state == cfm_pkg::CFM_ENTER_HOLD;
            disp_item <= pos;
            disp_value <= work[pos];
            case (state)
                cfm_pkg::CFM_NORMAL: disp_kind <= cfm_pkg::CFM_SHOW_NORMAL;
                cfm_pkg::CFM_ENTER_WAIT: begin
                    disp_kind <= cfm_pkg::CFM_SHOW_BANNER;
                end
                cfm_pkg::CFM_SETUP: begin
                    if (pos == `CFM_POS_BANNER)
                        disp_kind <= cfm_pkg::CFM_SHOW_BANNER;
                    else if (show_name)
                        disp_kind <= cfm_pkg::CFM_SHOW_NAME;
                    else disp_kind <= cfm_pkg::CFM_SHOW_VALUE;
                end
                cfm_pkg::CFM_STORE_MSG: begin
                    disp_kind <= cfm_pkg::CFM_SHOW_STORED;
                end
                default: disp_kind <= cfm_pkg::CFM_SHOW_BLANK;
            endcase
        end
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            adj_lock <= 1'b0;
        end else if (reg_wr && reg_addr == `CFM_REG_CTRL) begin
            adj_lock <= reg_wdata[`CFM_CTRL_LOCK_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || !reg_rd) begin
            reg_rdata <= 16'h0000;
        end else if (reg_addr == `CFM_REG_STATUS) begin
            reg_rdata <= {4'h0, state, pos};
        end else if (reg_addr == `CFM_REG_CTRL) begin
            reg_rdata <= {15'h0000, adj_lock};
        end else if (reg_addr[7:5] == `CFM_REG_VAL_BASE &&
                     reg_addr[4:0] != 5'h00 &&
                     reg_addr[4:0] <= `CFM_POS_LAST) begin
            reg_rdata <= work[reg_addr[4:0]];
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_hold_expired;
        state == cfm_pkg::CFM_ENTER_HOLD && step_up && hold_done;
    endsequence

    sequence s_step_last;
        state == cfm_pkg::CFM_SETUP && press && pos == `CFM_POS_LAST;
    endsequence

    property p_enter_banner;
        @(posedge sys_clk) disable iff (!rst_n)
        s_hold_expired |=> ##1 disp_kind == cfm_pkg::CFM_SHOW_BANNER;
    endproperty
    a_enter_banner: assert property (p_enter_banner)
        else $error("banner not shown after entry hold");

    property p_early_release;
        @(posedge sys_clk) disable iff (!rst_n)
        state == cfm_pkg::CFM_ENTER_HOLD && !step_up |=>
            state == cfm_pkg::CFM_NORMAL ##1 protect_enable;
    endproperty
    a_early_release: assert property (p_early_release)
        else $error("early release did not return to normal");

    property p_no_protect;
        @(posedge sys_clk) disable iff (!rst_n)
        setup_indicator |-> !protect_enable;
    endproperty
    a_no_protect: assert property (p_no_protect)
        else $error("protection active in setup mode");

    property p_step_next;
        @(posedge sys_clk) disable iff (!rst_n)
        state == cfm_pkg::CFM_SETUP && press && pos == `CFM_POS_ADDR |=>
            pos == `CFM_POS_BAUD && show_name;
    endproperty
    a_step_next: assert property (p_step_next)
        else $error("step did not advance one item");

    property p_wrap;
        @(posedge sys_clk) disable iff (!rst_n)
        s_step_last |=> pos == `CFM_POS_BANNER ##1
            disp_kind == cfm_pkg::CFM_SHOW_BANNER;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("last item did not wrap to banner");

    property p_store_pulse;
        @(posedge sys_clk) disable iff (!rst_n)
        nv_wr |-> $past(state) == cfm_pkg::CFM_STORE &&
            disp_kind == cfm_pkg::CFM_SHOW_BLANK;
    endproperty
    a_store_pulse: assert property (p_store_pulse)
        else $error("storage write outside store phase");

    property p_ranges;
        @(posedge sys_clk) disable iff (!rst_n)
        work[`CFM_POS_ADDR] >= `CFM_ADDR_MIN &&
        work[`CFM_POS_ADDR] <= `CFM_ADDR_MAX &&
        work[`CFM_POS_DEMAND] >= `CFM_DEMAND_MIN &&
        work[`CFM_POS_DEMAND] <= `CFM_DEMAND_MAX;
    endproperty
    a_ranges: assert property (p_ranges)
        else $error("station or demand value out of range");

    property p_fixed_sec;
        @(posedge sys_clk) disable iff (!rst_n)
        work[`CFM_POS_CTSEC_P] == `CFM_CTSEC &&
        work[`CFM_POS_CTSEC_G] == `CFM_CTSEC;
    endproperty
    a_fixed_sec: assert property (p_fixed_sec)
        else $error("secondary rating left 5");

    property p_indicator;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(setup_indicator) |->
            $past(state, 2) == cfm_pkg::CFM_ENTER_WAIT;
    endproperty
    a_indicator: assert property (p_indicator)
        else $error("indicator lit without entering setup");

endmodule : cfm_menu

// *** bench/cfm_operator.sv ***
// operator model: drives the step and adjust switches of the panel
module cfm_operator (
    input wire logic sys_clk, // system clock
    output logic step_up, // step switch raised
    output logic step_down, // step switch depressed
    output logic adj_up, // adjust switch raised
    output logic adj_down // adjust switch depressed
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {step_up, step_down, adj_up, adj_down} = 4'h0;
    // a step counts on release, so press for one cycle then let go
    task automatic tap_down;
        @(posedge sys_clk) step_down <= 1'b1;
        @(posedge sys_clk) step_down <= 1'b0;
    endtask : tap_down
    task automatic lift(input logic v);
        @(posedge sys_clk) step_up <= v;
    endtask : lift
    task automatic nudge(input logic up);
        @(posedge sys_clk) {adj_up, adj_down} <= up ? 2'h2 : 2'h1;
        @(posedge sys_clk) {adj_up, adj_down} <= 2'h0;
    endtask : nudge
endmodule : cfm_operator

// *** bench/front_panel_config_menu_tb.sv ***
// self-checking bench for the front-panel setup menu
module front_panel_config_menu_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [15:0] d;
        logic [1:0] a;
        logic [15:0] f;
    } cfm_row_t;
    logic sys_clk, rst_n, step_up, step_down, adj_up, adj_down;
    logic reg_wr, reg_rd, setup_indicator, protect_enable, nv_wr;
    logic aux_fitted, span_phase_hi, span_ground_hi;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, disp_value, nv_data;
    logic [4:0] disp_item, nv_addr;
    cfm_pkg::cfm_show_t disp_kind;
    int fail_count = 0, checks_done = 0, nv_count = 0, i;
    // default or strap level, adjust (1 up, 2 down), value after adjust; one row per item stepped through in the first walk
    cfm_row_t rows [21] = '{'{16'hDE,2'h2,16'hDD}, '{16'h2,2'h2,16'h1},
        '{16'h0,2'h1,16'h1}, '{16'h0,2'h2,16'h0}, '{16'h0,2'h0,16'h0},
        '{16'h0,2'h0,16'h0}, '{16'h64,2'h0,16'h64}, '{16'h64,2'h0,16'h64},
        '{16'h64,2'h0,16'h64}, '{16'h64,2'h0,16'h64}, '{16'h0,2'h2,16'h0},
        '{16'h0,2'h1,16'h1}, '{16'h5,2'h2,16'h5}, '{16'h5,2'h1,16'h5},
        '{16'h5,2'h0,16'h5}, '{16'h5,2'h0,16'h5}, '{16'h1,2'h1,16'h1},
        '{16'h0,2'h0,16'h0}, '{16'hF,2'h1,16'h10}, '{16'h0,2'h0,16'h0},
        '{16'h0,2'h0,16'h0}};
    cfm_operator op (.sys_clk(sys_clk), .step_up(step_up),
        .step_down(step_down), .adj_up(adj_up), .adj_down(adj_down));
    cfm_menu #(.HOLD_CYCLES(28'h14), .ALT_CYCLES(28'h8), .MSG_CYCLES(28'hA))
    uut (.sys_clk(sys_clk), .rst_n(rst_n), .step_up(step_up),
        .step_down(step_down), .adj_up(adj_up), .adj_down(adj_down),
        .aux_fitted(aux_fitted), .span_phase_hi(span_phase_hi),
        .span_ground_hi(span_ground_hi),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .setup_indicator(setup_indicator), .protect_enable(protect_enable),
        .disp_kind(disp_kind), .disp_item(disp_item),
        .disp_value(disp_value), .nv_wr(nv_wr), .nv_addr(nv_addr),
        .nv_data(nv_data));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic kind(input cfm_pkg::cfm_show_t k);
        chk(16'(disp_kind), 16'(k));
    endtask : kind
    // sample one step after the edge so registered outputs have landed
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wait_cyc
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge sys_clk) reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, input logic [15:0] e);
        @(posedge sys_clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge sys_clk) reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : reg_read
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        summarize();
    end
    // ------------------------------------------------------------------
    // reset, entry, item walk, exit with store
    // ------------------------------------------------------------------
    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {aux_fitted, span_phase_hi, span_ground_hi} = 3'h2;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        wait_cyc(1);
        kind(cfm_pkg::CFM_SHOW_NORMAL);
        chk(16'(setup_indicator), 16'h0);
        op.nudge(1'b1);
        op.lift(1'b1);
        wait_cyc(5);
        kind(cfm_pkg::CFM_SHOW_BLANK);
        op.lift(1'b0);
        wait_cyc(3);
        kind(cfm_pkg::CFM_SHOW_NORMAL);
        op.lift(1'b1);
        wait_cyc(25);
        kind(cfm_pkg::CFM_SHOW_BANNER);
        op.lift(1'b0);
        wait_cyc(3);
        chk(16'(setup_indicator), 16'h1);
        chk(16'(protect_enable), 16'h0);
        for (i = 0; i < 21; i++) begin
            op.tap_down();
            wait_cyc(3);
            chk(16'(disp_item), (i < 20) ? 16'(i + 1) : 16'h18);
            kind(cfm_pkg::CFM_SHOW_NAME);
            wait_cyc(10);
            kind(cfm_pkg::CFM_SHOW_VALUE);
            chk(disp_value, rows[i].d);
            if (rows[i].a != 2'h0) begin
                op.nudge(rows[i].a == 2'h1);
                wait_cyc(3);
                chk(disp_value, rows[i].f);
            end
        end
        op.lift(1'b1);
        op.lift(1'b0);
        wait_cyc(3);
        kind(cfm_pkg::CFM_SHOW_NAME);
        op.tap_down();
        wait_cyc(3);
        kind(cfm_pkg::CFM_SHOW_BANNER);
        reg_write(8'h01, 16'h1);
        reg_read(8'h01, 16'h1);
        reg_read(8'h21, 16'hDD);
        reg_read(8'h7F, 16'h0);
        op.lift(1'b1);
        wait_cyc(5);
        kind(cfm_pkg::CFM_SHOW_BLANK);
        // items whose value the walk changed plus the phase strap item, whose stored default is 0
        for (i = 0; i < 200 && disp_kind !== cfm_pkg::CFM_SHOW_STORED;
             i++) begin
            wait_cyc(1);
            if (nv_wr === 1'b1) begin
                nv_count++;
                chk(nv_data, rows[nv_addr - 5'h01].f);
            end
        end
        kind(cfm_pkg::CFM_SHOW_STORED);
        chk(16'(nv_count), 16'h6);
        op.lift(1'b0);
        for (i = 0; i < 50 && disp_kind !== cfm_pkg::CFM_SHOW_NORMAL;
             i++) begin
            wait_cyc(1);
        end
        kind(cfm_pkg::CFM_SHOW_NORMAL);
        chk(16'(protect_enable), 16'h1);
        // ------------------------------------------------------------------
        // second session: sub-items, straps, adjust lock left set
        // ------------------------------------------------------------------
        @(posedge sys_clk) {aux_fitted, span_ground_hi} <= 2'h3;
        op.lift(1'b1);
        wait_cyc(25);
        op.lift(1'b0);
        wait_cyc(3);
        for (i = 0; i < 20; i++) begin
            op.tap_down();
        end
        wait_cyc(3);
        chk(16'(disp_item), 16'h14);
        op.nudge(1'b1);
        wait_cyc(3);
        chk(disp_value, 16'h0);
        reg_write(8'h01, 16'h0);
        op.nudge(1'b1);
        wait_cyc(3);
        chk(disp_value, 16'h1);
        for (i = 0; i < 4; i++) begin
            op.tap_down();
            wait_cyc(3);
            chk(16'(disp_item), 16'(i + 8'h15));
        end
        reg_read(8'h32, 16'h1);
        summarize();
    end
endmodule : front_panel_config_menu_tb
